/* rtl/lcdr_cell.sv */
// Logic cell distributed RAM: two lookup tables as memory, logic table, flip-flops, AXI4-Lite control
//
// How it works
// RULE1: clocked mode writes data at address on active edge only if enable high.
// RULE2: address, data and enable are sampled together at the edge; enable is a plain enable.
// RULE3: write clock acts on rising edge by default, falling edge when configured.
// RULE4: write clock shares the flip-flop clock, each with its own inversion option.
// RULE5: one write-clock polarity serves both tables when both are memory.
// RULE6: write enable is active high and has no inversion option.
// RULE7: user keeps the phase after each active edge under one millisecond, never stopped.
// RULE8: 32-deep mode gives both tables the same low address; fifth bit selects table.
// RULE9: 16-deep modes keep the logic table and flip-flop capture choices usable.
// RULE10: dual-port mode joins both tables into one 16x1 array, two read ports.
// RULE11: dual-port mode reads and writes in one cycle, even at the same address.
// RULE12: dual-port mode always writes on the clock edge, never level-sensitive.
// RULE13: dual-port primary address reads and writes the first table; primary output shows it.
// RULE14: dual-port second table writes at primary address, reads at second read address.
// RULE15: secondary output shows the word at the second read address.
// RULE16: level mode writes the addressed word while enable high; data changes overwrite it.
// RULE17: user settles address before raising enable and drops enable before address changes.
// RULE18: user holds write data stable around the falling edge of enable.
// RULE19: user should derive the level write pulse from a double-rate or falling clock edge.
// RULE20: new designs should use the clocked write mode.
// RULE21: contents load from the initial words, or all zeros when none given.
// RULE22: contents change only on load or write; global set/reset leaves them alone.
// RULE23: reads are combinational from the addresses in every mode.
// RULE24: 32-deep mode uses the second data input as fifth address bit, first as data.
// RULE25: the selected write timing mode applies to both tables.
// RULE26: after a clocked write, the new value reads with no extra cycle.
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module lcdr_cell (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           reset,
    // AXI4-Lite write address and data
    input  wire logic [31:0]                    s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    // AXI4-Lite read
    input  wire logic [31:0]                    s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    // Memory user inputs
    input  wire logic [lcdr_pkg::TABLE_AW-1:0]  f_address,
    input  wire logic [lcdr_pkg::TABLE_AW-1:0]  g_address,
    input  wire logic [lcdr_pkg::TABLE_AW-1:0]  second_read_address,
    input  wire logic                           first_data_input,
    input  wire logic                           second_data_input,
    input  wire logic                           write_enable,
    input  wire logic                           write_clock,
    input  wire logic                           global_set_reset,
    // Memory user outputs
    output logic                                primary_read_out,
    output logic                                secondary_read_out,
    output logic                                logic_out,
    output logic                                x_q,
    output logic                                y_q
);

    localparam int DEPTH = lcdr_pkg::TABLE_DEPTH;
    localparam int AW    = lcdr_pkg::TABLE_AW;

    typedef struct packed {
        logic                  wclk_prev;
        logic                  aw_held;
        logic [31:0]           awaddr;
        logic                  w_held;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        lcdr_pkg::lcdr_mode_t  mode;
        logic                  level_mode;
        logic                  wclk_inv;
        logic                  flop_inv;
        logic [1:0]            x_sel;
        logic [1:0]            y_sel;
        logic                  load;
        logic [7:0]            logic_table;
        logic [DEPTH-1:0]      init_f;
        logic [DEPTH-1:0]      init_g;
        logic [15:0]           write_count;
        logic                  x_q;
        logic                  y_q;
    } lcdr_state_t;

    lcdr_state_t st_ff;
    lcdr_state_t nxt_st;

    logic [1:0]          tbl_wr_en;
    logic [AW-1:0]       tbl_wr_addr [2];
    logic [1:0]          tbl_wr_data;
    logic [AW-1:0]       tbl_rd_addr [2];
    logic [1:0]          tbl_rd_data;
    logic [DEPTH-1:0]    tbl_init [2];
    logic [DEPTH-1:0]    tbl_contents [2];
    logic                level_active;
    logic                wclk_edge;
    logic                flop_edge;
    logic                write_pulse;
    logic                is_32;
    logic                is_dual;
    logic                is_16x2;
    logic [31:0]         control_word;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [31:0] merge_strobes(input logic [31:0] old_v,
                                                  input logic [31:0] new_v,
                                                  input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic pick_source(input logic [1:0] sel,
                                         input logic       table_v,
                                         input logic       logic_v,
                                         input logic       data_v);
        case (sel)
            lcdr_pkg::SEL_TABLE: pick_source = table_v;
            lcdr_pkg::SEL_LOGIC: pick_source = logic_v;
            lcdr_pkg::SEL_DATA0: pick_source = data_v;
            default:             pick_source = table_v;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Memory datapath

    assign is_32   = (st_ff.mode == lcdr_pkg::MODE_32X1);
    assign is_dual = (st_ff.mode == lcdr_pkg::MODE_DUAL);
    assign is_16x2 = (st_ff.mode == lcdr_pkg::MODE_16X2);

    // Write clock is sampled as a level; its edge is found against last sample
    assign wclk_edge = st_ff.wclk_inv ? (~write_clock & st_ff.wclk_prev)     // RULE3 RULE5
                                      : (write_clock & ~st_ff.wclk_prev);
    assign flop_edge = st_ff.flop_inv ? (~write_clock & st_ff.wclk_prev)     // RULE4
                                      : (write_clock & ~st_ff.wclk_prev);

    assign level_active = st_ff.level_mode & ~is_dual;                       // RULE12 RULE25
    // Level mode writes on every cycle enable is high, so late data overwrites
    assign write_pulse  = level_active ? write_enable                        // RULE16 RULE6
                                       : (wclk_edge & write_enable);         // RULE1 RULE2

    // Table 0 is the first table, table 1 the second
    assign tbl_wr_en[0]   = write_pulse & ~(is_32 & second_data_input);      // RULE8 RULE24
    assign tbl_wr_en[1]   = write_pulse & (is_16x2 | is_dual | (is_32 & second_data_input)); // RULE10
    assign tbl_wr_addr[0] = f_address;                                       // RULE13
    assign tbl_wr_addr[1] = is_16x2 ? g_address : f_address;                 // RULE14 RULE8
    assign tbl_wr_data[0] = first_data_input;
    assign tbl_wr_data[1] = is_16x2 ? second_data_input : first_data_input;  // RULE24
    assign tbl_rd_addr[0] = f_address;                                       // RULE13 RULE23
    assign tbl_rd_addr[1] = is_dual ? second_read_address                    // RULE14 RULE15
                                    : (is_32 ? f_address : g_address);
    assign tbl_init[0]    = st_ff.init_f;
    assign tbl_init[1]    = st_ff.init_g;

    generate
        for (genvar t = 0; t < 2; t++) begin : g_table
            lcdr_table #(
                .DEPTH (DEPTH),
                .AW    (AW)
            ) u_table (
                .clk       (clk),
                .reset     (reset),
                .wr_en     (tbl_wr_en[t]),
                .wr_addr   (tbl_wr_addr[t]),
                .wr_data   (tbl_wr_data[t]),
                .load_en   (st_ff.load),                                     // RULE21 RULE22
                .load_word (tbl_init[t]),
                .rd_addr   (tbl_rd_addr[t]),
                .rd_data   (tbl_rd_data[t]),                                 // RULE11 RULE26
                .contents  (tbl_contents[t])
            );
        end
    endgenerate

    assign primary_read_out   = (is_32 & second_data_input) ? tbl_rd_data[1] : tbl_rd_data[0]; // RULE8
    assign secondary_read_out = (is_16x2 | is_dual) ? tbl_rd_data[1] : 1'b0; // RULE15
    assign logic_out          = st_ff.logic_table[{second_data_input, tbl_rd_data[1], tbl_rd_data[0]}]; // RULE9
    assign x_q                = st_ff.x_q;
    assign y_q                = st_ff.y_q;

    assign control_word = {22'h0, st_ff.y_sel, st_ff.x_sel, 1'b0, st_ff.flop_inv,
                           st_ff.wclk_inv, st_ff.level_mode, st_ff.mode};

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [31:0] merged;
        merged = 32'h0;
        nxt_st = st_ff;
        nxt_st.wclk_prev = write_clock;
        nxt_st.load      = 1'b0;

        if (write_pulse) begin
            nxt_st.write_count = st_ff.write_count + 16'h0001;
        end

        // Flip-flops clear on global set/reset; the tables do not
        if (global_set_reset) begin                                          // RULE22
            nxt_st.x_q = 1'b0;
            nxt_st.y_q = 1'b0;
        end else if (flop_edge) begin                                        // RULE4 RULE9
            nxt_st.x_q = pick_source(st_ff.x_sel, primary_read_out, logic_out, first_data_input);
            nxt_st.y_q = pick_source(st_ff.y_sel, tbl_rd_data[1], logic_out, first_data_input);
        end

        // Write channel: address and data taken in either order
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_st.aw_held = 1'b1;
            nxt_st.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_st.w_held = 1'b1;
            nxt_st.wdata  = s_axi_wdata;
            nxt_st.wstrb  = s_axi_wstrb;
        end
        if (st_ff.aw_held && st_ff.w_held) begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = lcdr_pkg::RESP_OKAY;
            case (st_ff.awaddr)
                lcdr_pkg::OFF_CONTROL: begin
                    merged            = merge_strobes(control_word, st_ff.wdata, st_ff.wstrb);
                    nxt_st.mode       = lcdr_pkg::lcdr_mode_t'(merged[lcdr_pkg::CTL_MODE_LSB +: 2]);
                    nxt_st.level_mode = merged[lcdr_pkg::CTL_LEVEL_BIT];
                    nxt_st.wclk_inv   = merged[lcdr_pkg::CTL_WINV_BIT];
                    nxt_st.flop_inv   = merged[lcdr_pkg::CTL_FINV_BIT];
                    nxt_st.load       = merged[lcdr_pkg::CTL_LOAD_BIT];
                    nxt_st.x_sel      = merged[lcdr_pkg::CTL_XSEL_LSB +: 2];
                    nxt_st.y_sel      = merged[lcdr_pkg::CTL_YSEL_LSB +: 2];
                end
                lcdr_pkg::OFF_LOGIC_TABLE: begin
                    merged             = merge_strobes({24'h0, st_ff.logic_table}, st_ff.wdata, st_ff.wstrb);
                    nxt_st.logic_table = merged[7:0];
                end
                lcdr_pkg::OFF_INIT_F: begin
                    merged        = merge_strobes({16'h0, st_ff.init_f}, st_ff.wdata, st_ff.wstrb);
                    nxt_st.init_f = merged[DEPTH-1:0];
                end
                lcdr_pkg::OFF_INIT_G: begin
                    merged        = merge_strobes({16'h0, st_ff.init_g}, st_ff.wdata, st_ff.wstrb);
                    nxt_st.init_g = merged[DEPTH-1:0];
                end
                lcdr_pkg::OFF_F_CONTENT, lcdr_pkg::OFF_G_CONTENT, lcdr_pkg::OFF_WRITE_COUNT: begin
                    nxt_st.bresp = lcdr_pkg::RESP_OKAY;
                end
                default: begin
                    nxt_st.bresp = lcdr_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Read channel
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = lcdr_pkg::RESP_OKAY;
            case (s_axi_araddr)
                lcdr_pkg::OFF_CONTROL:     nxt_st.rdata = control_word;
                lcdr_pkg::OFF_LOGIC_TABLE: nxt_st.rdata = {24'h0, st_ff.logic_table};
                lcdr_pkg::OFF_INIT_F:      nxt_st.rdata = {16'h0, st_ff.init_f};
                lcdr_pkg::OFF_INIT_G:      nxt_st.rdata = {16'h0, st_ff.init_g};
                lcdr_pkg::OFF_F_CONTENT:   nxt_st.rdata = {16'h0, tbl_contents[0]};
                lcdr_pkg::OFF_G_CONTENT:   nxt_st.rdata = {16'h0, tbl_contents[1]};
                lcdr_pkg::OFF_WRITE_COUNT: nxt_st.rdata = {16'h0, st_ff.write_count};
                default: begin
                    nxt_st.rdata = 32'h0;
                    nxt_st.rresp = lcdr_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_ff             <= '0;
            st_ff.mode        <= lcdr_pkg::MODE_16X2;
            st_ff.logic_table <= lcdr_pkg::LOGIC_TABLE_RESET;
            st_ff.init_f      <= lcdr_pkg::INIT_RESET;
            st_ff.init_g      <= lcdr_pkg::INIT_RESET;
            st_ff.write_count <= lcdr_pkg::COUNT_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshakes

    // One write and one read at a time: channels stall while an answer waits
    assign s_axi_awready = ~st_ff.aw_held & ~st_ff.bvalid;
    assign s_axi_wready  = ~st_ff.w_held & ~st_ff.bvalid;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_arready = ~st_ff.rvalid;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rdata   = st_ff.rdata;
    assign s_axi_rresp   = st_ff.rresp;

endmodule

/* rtl/lcdr_pkg.sv */
// Constants and types shared by the logic cell distributed RAM block
package lcdr_pkg;

    // Table geometry
    localparam int TABLE_DEPTH = 16;
    localparam int TABLE_AW    = 4;

    // Storage arrangement of the cell
    typedef enum logic [1:0] {
        MODE_16X2,
        MODE_16X1,
        MODE_32X1,
        MODE_DUAL
    } lcdr_mode_t;

    // Register byte offsets
    localparam logic [31:0] OFF_CONTROL     = 32'h0000_0000;
    localparam logic [31:0] OFF_LOGIC_TABLE = 32'h0000_0004;
    localparam logic [31:0] OFF_INIT_F      = 32'h0000_0008;
    localparam logic [31:0] OFF_INIT_G      = 32'h0000_000c;
    localparam logic [31:0] OFF_F_CONTENT   = 32'h0000_0010;
    localparam logic [31:0] OFF_G_CONTENT   = 32'h0000_0014;
    localparam logic [31:0] OFF_WRITE_COUNT = 32'h0000_0018;

    // Control register field positions
    localparam int CTL_MODE_LSB  = 0;
    localparam int CTL_LEVEL_BIT = 2;
    localparam int CTL_WINV_BIT  = 3;
    localparam int CTL_FINV_BIT  = 4;
    localparam int CTL_LOAD_BIT  = 5;
    localparam int CTL_XSEL_LSB  = 6;
    localparam int CTL_YSEL_LSB  = 8;

    // Values after reset
    localparam logic [7:0]  LOGIC_TABLE_RESET = 8'h00;
    localparam logic [15:0] INIT_RESET        = 16'h0000;
    localparam logic [15:0] COUNT_RESET       = 16'h0000;

    // Flip-flop capture sources
    localparam logic [1:0] SEL_TABLE = 2'h0;
    localparam logic [1:0] SEL_LOGIC = 2'h1;
    localparam logic [1:0] SEL_DATA0 = 2'h2;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* rtl/lcdr_table.sv */
// One 16x1 lookup table used as memory: one write port, one combinational read port
`timescale 1ns/10ps
module lcdr_table #(
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic             wr_data,
    // Initial contents load
    input  wire logic             load_en,
    input  wire logic [DEPTH-1:0] load_word,
    // Read port
    input  wire logic [AW-1:0]    rd_addr,
    output logic                  rd_data,
    output logic [DEPTH-1:0]      contents
);

    typedef struct packed {
        logic [DEPTH-1:0] bits;
    } lcdr_table_state_t;

    lcdr_table_state_t st_ff;
    lcdr_table_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (load_en) begin
            nxt_st.bits = load_word;
        end else if (wr_en) begin
            nxt_st.bits[wr_addr] = wr_data;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // No output register: a write shows at the next read with no added cycle
    assign rd_data  = st_ff.bits[rd_addr];
    assign contents = st_ff.bits;

endmodule

/* test/lcdr_cell_chk.sv */
// Concurrent checks on the cell's ports
`timescale 1ns/10ps
module lcdr_cell_chk (
    // Clock and reset
    input logic        clk,
    input logic        reset,
    // Register bus
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    // Memory side
    input logic [3:0]  f_address,
    input logic [3:0]  g_address,
    input logic [3:0]  second_read_address,
    input logic        second_data_input,
    input logic        write_enable,
    input logic        global_set_reset,
    input logic        primary_read_out,
    input logic        secondary_read_out,
    input logic        x_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Load lands two edges after the bus write is taken
    sequence s_quiet;
        (!s_axi_awvalid [*4]) and (!write_enable [*4]);
    endsequence
    property p_hold;
        s_quiet ##0 $stable({f_address, g_address, second_read_address, second_data_input})
            |-> $stable({primary_read_out, secondary_read_out});
    endproperty

    a_contents_hold: assert property (p_hold)
        else $error("read out moved");
    a_gsr_flops: assert property (global_set_reset |=> !x_q)
        else $error("flop not cleared");
    a_bresp_time: assert property (s_wr_take |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("bvalid timing");
    a_rresp_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write during bvalid");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read during rvalid");
    a_bvalid_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid repeated");
endmodule

bind lcdr_cell lcdr_cell_chk CHK (.*);

/* test/lcdr_cell_tb.sv */
// Self-checking bench for the cell
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module lcdr_cell_tb;
    logic        clk = 1'b0, reset = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, first_data_input = 1'b0, second_data_input = 1'b0;
    logic        write_enable = 1'b0, global_set_reset = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf, f_address = 4'h0, g_address = 4'h0, second_read_address = 4'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, write_clock;
    logic        primary_read_out, secondary_read_out, logic_out, x_q, y_q;
    int          n_mismatch = 0, n_compared = 0;

    lcdr_cell DUT (.*);
    lcdr_user PRT (.clk, .reset, .write_clock);

    ////////////////////////////////////////////////////////////////////////////////
    task axw(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        rr = s_axi_bresp;
    endtask

    task axr(input logic [31:0] a);
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rr = s_axi_rresp;
    endtask

    // One-cycle enable at a rising (ph=1) or falling (ph=0) write edge
    task pulse(input logic [3:0] a, input logic d, input logic ph);
        do @(posedge clk); while (write_clock !== !ph);
        f_address        <= a;
        first_data_input <= d;
        write_enable     <= 1'b1;
        @(posedge clk);
        write_enable <= 1'b0;
        @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task t_regs;
        for (int k = 0; k < 7; k++) begin
            axr(32'(4 * k));
            `CHK("reset value", 32'h0, rd)
        end
        axr(32'h40);
        `CHK("unmapped resp", lcdr_pkg::RESP_SLVERR, rr)
        axw(lcdr_pkg::OFF_WRITE_COUNT, 32'h5);
        `CHK("ro write resp", lcdr_pkg::RESP_OKAY, rr)
        $display("done regs");
    endtask

    task t_16x2;
        @(posedge clk);
        g_address         <= 4'h7;
        second_data_input <= 1'b1;
        pulse(4'h2, 1'b1, 1'b1);
        `CHK("table0", 1'b1, primary_read_out)
        `CHK("table1", 1'b1, secondary_read_out)
        pulse(4'h2, 1'b0, 1'b0);
        `CHK("falling ignored", 1'b1, primary_read_out)
        axr(lcdr_pkg::OFF_WRITE_COUNT);
        `CHK("write count", 32'h1, rd)
        $display("done 16x2");
    endtask

    task t_fall;
        axw(lcdr_pkg::OFF_CONTROL, 32'h9);
        pulse(4'h4, 1'b1, 1'b1);
        `CHK("rising ignored", 1'b0, primary_read_out)
        pulse(4'h4, 1'b1, 1'b0);
        `CHK("falling write", 1'b1, primary_read_out)
        $display("done falling");
    endtask

    task t_dual;
        axw(lcdr_pkg::OFF_CONTROL, 32'h7);
        @(posedge clk);
        second_read_address <= 4'h9;
        pulse(4'h9, 1'b1, 1'b1);
        `CHK("dual primary", 1'b1, primary_read_out)
        `CHK("dual secondary", 1'b1, secondary_read_out)
        pulse(4'h3, 1'b1, 1'b0);
        `CHK("level ignored", 1'b0, primary_read_out)
        `CHK("second port", 1'b1, secondary_read_out)
        pulse(4'h9, 1'b0, 1'b1);
        `CHK("same address", 1'b0, secondary_read_out)
        $display("done dual");
    endtask

    task t_32;
        axw(lcdr_pkg::OFF_CONTROL, 32'h2);
        @(posedge clk);
        second_data_input <= 1'b1;
        pulse(4'h3, 1'b1, 1'b1);
        `CHK("upper half", 1'b1, primary_read_out)
        @(posedge clk);
        second_data_input <= 1'b0;
        @(negedge clk);
        `CHK("lower half", 1'b0, primary_read_out)
        $display("done 32x1");
    endtask

    // Address settles first; data held past enable
    task t_level;
        axw(lcdr_pkg::OFF_CONTROL, 32'h5);
        @(posedge clk);
        f_address <= 4'h6;
        @(posedge clk);
        first_data_input <= 1'b0;
        write_enable     <= 1'b1;
        @(posedge clk);
        first_data_input <= 1'b1;
        @(posedge clk);
        write_enable <= 1'b0;
        @(negedge clk);
        `CHK("level overwrite", 1'b1, primary_read_out)
        axr(lcdr_pkg::OFF_WRITE_COUNT);
        `CHK("level count", 32'h7, rd)
        $display("done level");
    endtask

    task t_init;
        axw(lcdr_pkg::OFF_INIT_F, 32'h1);
        axw(lcdr_pkg::OFF_CONTROL, 32'h21);
        @(negedge clk);
        `CHK("load clears", 1'b0, primary_read_out)
        @(posedge clk);
        f_address <= 4'h0;
        axw(lcdr_pkg::OFF_LOGIC_TABLE, 32'h2);
        global_set_reset <= 1'b1;
        @(negedge clk);
        `CHK("logic and flops", 3'h6, {logic_out, x_q, y_q})
        @(posedge clk);
        global_set_reset <= 1'b0;
        @(negedge clk);
        `CHK("kept over gsr", 1'b1, primary_read_out)
        $display("done init");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task test_done;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        forever #10 clk = ~clk;
    end

    initial begin
        #200000;
        n_mismatch++;
        test_done;
    end

    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_regs;
        t_16x2;
        t_fall;
        t_dual;
        t_32;
        t_level;
        t_init;
        test_done;
    end
endmodule

/* test/lcdr_user.sv */
// Partner model: user logic driving the write clock
`timescale 1ns/10ps
module lcdr_user (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Write clock to the cell
    output logic      write_clock
);
    // One clk per phase, never parked
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            write_clock <= 1'b0;
        end else begin
            write_clock <= ~write_clock;
        end
    end
endmodule
